/* src/bmr_pkg.sv */
// Package for the boot-mode and running-reset block.
// Assumes a single 10 MHz core clock and an active-low power-up reset.
package bmr_pkg;

  // ----------------------------------------
  // Boot-select codes
  // ----------------------------------------
  localparam logic [2:0] BMR_SEL_SPI_SLAVE = 3'h0;
  localparam logic [2:0] BMR_SEL_SPI_MASTER = 3'h1;
  localparam logic [2:0] BMR_SEL_PAR_FLASH = 3'h2;
  localparam logic [2:0] BMR_SEL_ROM_EXEC = 3'h3;
  localparam int BMR_SEL_W = 3;

  typedef enum logic [4:0] {
    BMR_MODE_SPI_SLAVE = 5'h01,
    BMR_MODE_SPI_MASTER = 5'h02,
    BMR_MODE_PAR_FLASH = 5'h04,
    BMR_MODE_ROM_EXEC = 5'h08,
    BMR_MODE_RESERVED = 5'h10
  } bmr_mode_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    BMR_ST_CAPTURE = 4'h1,
    BMR_ST_LOAD = 4'h2,
    BMR_ST_RUN = 4'h4,
    BMR_ST_RUN_RESET = 4'h8
  } bmr_state_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int BMR_CLK_HZ = 10_000_000;
  localparam int BMR_RUNRST_NS = 1000;
  localparam int BMR_RUNRST_CYC = (BMR_RUNRST_NS * (BMR_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BMR_SYNC_STAGES = 3;
  localparam logic [2:0] BMR_SYNC_RESET = 3'h7;

endpackage : bmr_pkg

/* src/bmr_sync.sv */
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; out changes when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module bmr_sync
  import bmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);

  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic out_ff;
  logic nxt_out;

  always_comb begin
    nxt_stage = {stage_ff[1:0], din};
    nxt_out = out_ff;
    if (stage_ff[1] == stage_ff[2]) begin
      nxt_out = stage_ff[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_ff <= BMR_SYNC_RESET;
      out_ff <= 1'b1;
    end else begin
      stage_ff <= nxt_stage;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;

endmodule : bmr_sync
`default_nettype wire

/* src/bmr_boot_ctrl.sv */
// Boot-mode selection and running-reset control.
// Assumes loaders report completion on load_done and reset pins are active low.
`timescale 1ns/100ps
`default_nettype none
module bmr_boot_ctrl
  import bmr_pkg::*;
#(
  parameter int RUNRST_CYCLES = BMR_RUNRST_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] boot_select_pins,
  input wire logic load_done,
  input wire logic reset_out_running_reset_in_i,
  output logic reset_out_running_reset_in_o,
  output logic reset_out_running_reset_in_oe,
  output logic load_spi_slave,
  output logic load_spi_master,
  output logic load_par_flash,
  output logic rom_exec,
  output logic mode_reserved,
  output logic core_rst_n,
  output logic periph_rst_n,
  output logic pll_sdram_rst_n
);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  if (RUNRST_CYCLES < 1 || RUNRST_CYCLES > 4096) begin : g_bad_len
    $error("RUNRST_CYCLES out of range");
  end

  if (BMR_SYNC_STAGES != 3) begin : g_bad_sync
    $error("strap settle count assumes three synchroniser stages");
  end

  // ----------------------------------------
  // Request pin synchroniser
  // ----------------------------------------
  logic req_lvl;
  // The pin is read back while driven, so the request is only honoured while released.
  bmr_sync u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din(reset_out_running_reset_in_i),
    .dout(req_lvl)
  );

  // ----------------------------------------
  // Strap pin synchronisers
  // ----------------------------------------
  wire logic [BMR_SEL_W-1:0] sel_sync;
  // Straps come from pins, so each bit is filtered like any other asynchronous input.
  for (genvar b = 0; b < BMR_SEL_W; b++) begin : g_sel_sync
    bmr_sync u_sel_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .din(boot_select_pins[b]),
      .dout(sel_sync[b])
    );
  end

  // ----------------------------------------
  // Strap settle counter
  // ----------------------------------------
  logic [2:0] settle_ff;
  logic [2:0] nxt_settle;
  logic settle_done;

  // The capture waits until the synchronisers have replaced their reset value with the straps.
  assign settle_done = (settle_ff == 3'(BMR_SYNC_STAGES + 1));

  always_comb begin
    nxt_settle = settle_ff;
    if (!settle_done) begin
      nxt_settle = settle_ff + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff <= 3'h0;
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  bmr_state_t state_ff;
  bmr_state_t nxt_state;
  bmr_mode_t mode_ff;
  bmr_mode_t nxt_mode;
  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;
  logic req_prev_ff;
  logic nxt_req_prev;
  logic req_fall;

  assign req_fall = req_prev_ff && !req_lvl;

  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_cnt = cnt_ff;
    nxt_req_prev = req_lvl;
    unique case (state_ff)
      BMR_ST_CAPTURE: begin
        // Straps are static during reset, so one capture once they have settled suffices.
        if (settle_done) begin
          unique case (sel_sync)
            BMR_SEL_SPI_SLAVE: begin
              nxt_mode = BMR_MODE_SPI_SLAVE;
            end
            BMR_SEL_SPI_MASTER: begin
              nxt_mode = BMR_MODE_SPI_MASTER;
            end
            BMR_SEL_PAR_FLASH: begin
              nxt_mode = BMR_MODE_PAR_FLASH;
            end
            BMR_SEL_ROM_EXEC: begin
              nxt_mode = BMR_MODE_ROM_EXEC;
            end
            default: begin
              nxt_mode = BMR_MODE_RESERVED;
            end
          endcase
          if (sel_sync == BMR_SEL_ROM_EXEC) begin
            nxt_state = BMR_ST_RUN;
          end else begin
            nxt_state = BMR_ST_LOAD;
          end
        end
      end
      BMR_ST_LOAD: begin
        if (load_done && mode_ff != BMR_MODE_RESERVED) begin
          nxt_state = BMR_ST_RUN;
        end
      end
      BMR_ST_RUN: begin
        if (req_fall) begin
          nxt_state = BMR_ST_RUN_RESET;
          nxt_cnt = 12'(RUNRST_CYCLES - 1);
        end
      end
      BMR_ST_RUN_RESET: begin
        if (cnt_ff == 12'h000) begin
          nxt_state = BMR_ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 12'h001;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= BMR_ST_CAPTURE;
      mode_ff <= BMR_MODE_RESERVED;
      cnt_ff <= 12'h000;
      req_prev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      req_prev_ff <= nxt_req_prev;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic out_rst_n_ff;
  logic nxt_out_rst_n;
  logic pll_rst_n_ff;
  logic nxt_pll_rst_n;
  logic [4:0] ld_ff;
  logic [4:0] nxt_ld;

  always_comb begin
    nxt_out_rst_n = (nxt_state == BMR_ST_RUN);
    nxt_pll_rst_n = 1'b1;
    nxt_ld = 5'h00;
    if (nxt_state == BMR_ST_LOAD) begin
      nxt_ld[0] = (nxt_mode == BMR_MODE_SPI_SLAVE);
      nxt_ld[1] = (nxt_mode == BMR_MODE_SPI_MASTER);
      nxt_ld[2] = (nxt_mode == BMR_MODE_PAR_FLASH);
    end
    nxt_ld[3] = (nxt_mode == BMR_MODE_ROM_EXEC);
    nxt_ld[4] = (nxt_mode == BMR_MODE_RESERVED) && (nxt_state != BMR_ST_CAPTURE);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_rst_n_ff <= 1'b0;
      pll_rst_n_ff <= 1'b0;
      ld_ff <= 5'h00;
    end else begin
      out_rst_n_ff <= nxt_out_rst_n;
      pll_rst_n_ff <= nxt_pll_rst_n;
      ld_ff <= nxt_ld;
    end
  end

  assign core_rst_n = out_rst_n_ff;
  assign periph_rst_n = out_rst_n_ff;
  assign pll_sdram_rst_n = pll_rst_n_ff;
  assign load_spi_slave = ld_ff[0];
  assign load_spi_master = ld_ff[1];
  assign load_par_flash = ld_ff[2];
  assign rom_exec = ld_ff[3];
  assign mode_reserved = ld_ff[4];
  // Pin is driven low only while the core is held; otherwise released for requests.
  assign reset_out_running_reset_in_o = 1'b0;
  assign reset_out_running_reset_in_oe = !out_rst_n_ff;

endmodule : bmr_boot_ctrl
`default_nettype wire

/* tb/bmr_host_model.sv */
// Model of the boot loader and the external host on the reset pin.
// Assumes a pull-up on the shared reset pin.
`timescale 1ns/100ps
`default_nettype none
module bmr_host_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_req,
  input wire logic busy,
  input wire logic reset_out_running_reset_in_o,
  input wire logic reset_out_running_reset_in_oe,
  output logic reset_out_running_reset_in_i,
  output logic load_done
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  // The wire is low while either party pulls it down.
  assign reset_out_running_reset_in_i = !(host_req ||
    (reset_out_running_reset_in_oe && !reset_out_running_reset_in_o));
  // The loader takes a few cycles, so completion never comes at once.
  always_comb nxt_cnt = busy ? cnt_ff + 3'h1 : 3'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 3'h0;
    else cnt_ff <= nxt_cnt;
  end
  assign load_done = (cnt_ff == 3'h5);
endmodule : bmr_host_model
`default_nettype wire

/* tb/bmr_boot_monitor.sv */
// Checker for the boot-mode and running-reset block.
// Assumes it is bound to bmr_boot_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module bmr_boot_monitor #(parameter int RUNRST_CYCLES = 10) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reset_out_running_reset_in_i,
  input wire logic reset_out_running_reset_in_o,
  input wire logic reset_out_running_reset_in_oe,
  input wire logic load_spi_slave,
  input wire logic load_spi_master,
  input wire logic load_par_flash,
  input wire logic rom_exec,
  input wire logic mode_reserved,
  input wire logic core_rst_n,
  input wire logic pll_sdram_rst_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic ran_ff, nxt_ran;
  logic [7:0] low_ff, nxt_low;
  wire [2:0] ld = {load_spi_slave, load_spi_master, load_par_flash};
  always_comb begin
    nxt_ran = ran_ff | core_rst_n;
    nxt_low = core_rst_n ? 8'h00 : low_ff + 8'h01;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ran_ff <= 1'b0;
      low_ff <= 8'h00;
    end else begin
      ran_ff <= nxt_ran;
      low_ff <= nxt_low;
    end
  end
  a_pll_kept: assert property ($past(rst_n) |-> pll_sdram_rst_n)
    else $error("pll reset low");
  a_one_mode: assert property ($past(rst_n) |-> $onehot0({ld, rom_exec, mode_reserved}))
    else $error("modes overlap");
  a_rom_run: assert property ($rose(rom_exec) |-> core_rst_n && ld == 3'h0)
    else $error("rom mode not running");
  a_res_park: assert property (mode_reserved |-> !core_rst_n)
    else $error("reserved code runs");
  a_mode_held: assert property ($past(rst_n, 6) |-> $stable({rom_exec, mode_reserved}))
    else $error("mode changed");
  a_no_reload: assert property (ran_ff |-> ld == 3'h0)
    else $error("load after run");
  a_req_seen: assert property (core_rst_n && !reset_out_running_reset_in_oe
    && $fell(reset_out_running_reset_in_i) |-> ##[1:6] !core_rst_n)
    else $error("request missed");
  a_run_len: assert property ($rose(core_rst_n) && ran_ff |-> low_ff == RUNRST_CYCLES)
    else $error("running reset length");
  a_pin_drive: assert property ($past(rst_n) |->
    reset_out_running_reset_in_oe == !core_rst_n && !reset_out_running_reset_in_o)
    else $error("pin drive wrong");
endmodule : bmr_boot_monitor
bind bmr_boot_ctrl bmr_boot_monitor #(.RUNRST_CYCLES(RUNRST_CYCLES)) u_mon (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .reset_out_running_reset_in_i(reset_out_running_reset_in_i),
  .reset_out_running_reset_in_o(reset_out_running_reset_in_o),
  .reset_out_running_reset_in_oe(reset_out_running_reset_in_oe),
  .load_spi_slave(load_spi_slave),
  .load_spi_master(load_spi_master),
  .load_par_flash(load_par_flash),
  .rom_exec(rom_exec),
  .mode_reserved(mode_reserved),
  .core_rst_n(core_rst_n),
  .pll_sdram_rst_n(pll_sdram_rst_n)
);
`default_nettype wire

/* tb/test_boot_mode_and_running_reset.sv */
// Testbench for the boot-mode and running-reset block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_boot_mode_and_running_reset;
  logic ref_clk = 1'b0, rst_n = 1'b0, host_req = 1'b0, busy, load_done;
  logic [2:0] boot_select_pins = 3'h0;
  logic reset_out_running_reset_in_i, reset_out_running_reset_in_o;
  logic reset_out_running_reset_in_oe, load_spi_slave, load_spi_master, load_par_flash;
  logic rom_exec, mode_reserved, core_rst_n, periph_rst_n, pll_sdram_rst_n;
  int num_errors = 0, comparisons = 0;
  // A reserved code also keeps the loader busy, though boot_test resets before any completion pulse comes.
  assign busy = load_spi_slave | load_spi_master | load_par_flash | mode_reserved;
  always #50 ref_clk = ~ref_clk;
  // A short running-reset pulse keeps the run brief.
  bmr_boot_ctrl #(.RUNRST_CYCLES(2)) DUT (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .boot_select_pins(boot_select_pins),
    .load_done(load_done),
    .reset_out_running_reset_in_i(reset_out_running_reset_in_i),
    .reset_out_running_reset_in_o(reset_out_running_reset_in_o),
    .reset_out_running_reset_in_oe(reset_out_running_reset_in_oe),
    .load_spi_slave(load_spi_slave),
    .load_spi_master(load_spi_master),
    .load_par_flash(load_par_flash),
    .rom_exec(rom_exec),
    .mode_reserved(mode_reserved),
    .core_rst_n(core_rst_n),
    .periph_rst_n(periph_rst_n),
    .pll_sdram_rst_n(pll_sdram_rst_n)
  );
  bmr_host_model u_host (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .host_req(host_req),
    .busy(busy),
    .reset_out_running_reset_in_o(reset_out_running_reset_in_o),
    .reset_out_running_reset_in_oe(reset_out_running_reset_in_oe),
    .reset_out_running_reset_in_i(reset_out_running_reset_in_i),
    .load_done(load_done)
  );
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_core(input logic lvl);
    for (int i = 0; i < 20 && core_rst_n !== lvl; i++) @(negedge ref_clk);
  endtask : wait_core
  function automatic logic [4:0] modes();
    return {mode_reserved, rom_exec, load_par_flash, load_spi_master, load_spi_slave};
  endfunction : modes
  task automatic boot_test(input logic [2:0] code);
    rst_n = 1'b0;
    boot_select_pins = code;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    // The straps are taken at the fifth edge after release, once their filters have settled.
    repeat (6) @(negedge ref_clk);
    check(modes(), code[2] ? 5'h10 : 5'h01 << code);
    wait_core(!code[2]);
    check({3'h0, core_rst_n, pll_sdram_rst_n}, {3'h0, !code[2], 1'b1});
    $display("boot test with code %h done", code);
  endtask : boot_test
  task automatic run_reset_test();
    boot_test(3'h2);
    boot_select_pins = 3'h3;
    repeat (2) begin
      repeat (5) @(negedge ref_clk);
      host_req = 1'b1;
      repeat (4) @(negedge ref_clk);
      host_req = 1'b0;
      wait_core(1'b0);
      check({1'b0, core_rst_n, periph_rst_n, pll_sdram_rst_n,
        reset_out_running_reset_in_oe}, 5'h03);
      wait_core(1'b1);
      check(modes(), 5'h00);
      check({4'h0, periph_rst_n}, 5'h01);
    end
    $display("running reset test done");
  endtask : run_reset_test
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    for (int c = 0; c < 8; c++) boot_test(c[2:0]);
    run_reset_test();
    summarize();
  end
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule : test_boot_mode_and_running_reset
`default_nettype wire
